// *** design/sbr_read_core.sv ***
// bank activation tracking and read burst output of the memory device
// What this block does
// - reads soon after ACTIVATE are accepted; posted latency covers activation delay.
// - read gives column and bank; A10 high selects auto precharge.
// - first data element RL clocks after read, then one per clock edge.
// - strobe driven low as preamble before data; lines float after burst.
// - strobe held low half a clock after last transition, then released.
// - reads tCCD apart concatenate; chopped bursts leave a gap.
// - no ACTIVATE to a bank until tRP after its last precharge.
// - auto precharge starts AL plus the larger of tRTP and four clocks after read, held for tRAS.
// - precharge period starts at the actual internal precharge instant.
// - internal precharge at least four clocks after the final prefetch.
// - outside the burst and its preamble, termination follows the termination input.
// - eight-element burst for field 00, or field 01 with A12 high.
// - field 01 with A12 low gives a four-element chop.
// - field 10 chops every burst to four elements.
module sbr_read_core (
  input  wire logic                    clock,        // system clock
  input  wire logic                    reset,        // synchronous reset, active high
  input  wire logic [3:0]              cfg_al,       // additive latency, cycles
  input  wire logic [4:0]              cfg_cl,       // CAS latency, cycles; read latency is this plus cfg_al
  input  wire logic [1:0]              cfg_bl,       // burst-length field
  output logic      [7:0]              bank_open,    // open banks, system clock
  output logic                         read_busy,    // read data on the bus
  input  wire logic                    link_clock,   // memory clock
  input  wire logic                    cs_n,         // chip select, active low
  input  wire logic                    ras_n,        // row strobe, active low
  input  wire logic                    cas_n,        // column strobe, active low
  input  wire logic                    we_n,         // write enable, active low
  input  wire logic [2:0]              bank,         // bank address
  input  wire logic [13:0]             addr,         // row or column address
  input  wire logic                    odt,          // termination request
  output logic      [7:0]              dq_rise,      // data, first half cycle
  output logic      [7:0]              dq_fall,      // data, second half cycle
  output logic                         dq_oe_n,      // data drive enable, active low
  output logic                         dqs_rise,     // strobe, first half cycle
  output logic                         dqs_fall,     // strobe, second half cycle
  output logic                         dqs_oe_n,     // strobe drive enable, active low
  output logic                         term_en       // on-die termination active
);
  // ----------------------------------------------------------------
  // configuration handshake, system side
  // ----------------------------------------------------------------
  logic [10:0] cfg_hold;
  logic        cfg_req;
  logic        cfg_ack_s;
  logic        link_reset;
  logic        cfg_req_s;
  logic        cfg_ack;
  logic [10:0] cfg_link;
  logic [7:0]  open_q;
  logic        busy_q;
  wire  [10:0] cfg_in   = {cfg_al, cfg_cl, cfg_bl};
  wire         cfg_idle = (cfg_ack_s == cfg_req);

  always_ff @(posedge clock) begin
    if (reset) begin
      cfg_hold <= 11'h000;
      cfg_req  <= 1'b0;
    end else if (cfg_idle && (cfg_in != cfg_hold)) begin
      cfg_hold <= cfg_in;
      cfg_req  <= ~cfg_req;
    end
  end

  sbr_sync #(.WIDTH(1)) u_ack  (.clock(clock), .d(cfg_ack), .q(cfg_ack_s));
  sbr_sync #(.WIDTH(8)) u_open (.clock(clock), .d(open_q),  .q(bank_open));
  sbr_sync #(.WIDTH(1)) u_busy (.clock(clock), .d(busy_q),  .q(read_busy));

  // ----------------------------------------------------------------
  // link side reset and configuration
  // ----------------------------------------------------------------
  sbr_sync #(.WIDTH(1)) u_rst (.clock(link_clock), .d(reset),   .q(link_reset));
  sbr_sync #(.WIDTH(1)) u_req (.clock(link_clock), .d(cfg_req), .q(cfg_req_s));

  always_ff @(posedge link_clock) begin
    if (link_reset) begin
      cfg_ack  <= 1'b0;
      cfg_link <= 11'h000;
    end else if (cfg_req_s != cfg_ack) begin
      cfg_link <= cfg_hold;
      cfg_ack  <= cfg_req_s;
    end
  end

  wire [3:0] al = cfg_link[10:7];
  wire [4:0] cl = cfg_link[6:2];
  wire [1:0] bl = cfg_link[1:0];
  wire [5:0] rl = {2'h0, al} + {1'b0, cl};

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire cmd_act = !cs_n && !ras_n && cas_n && we_n;
  wire cmd_rd  = !cs_n && ras_n && !cas_n && we_n;
  wire cmd_pre = !cs_n && !ras_n && cas_n && !we_n;
  localparam int AP_BIT_L = sbr_pkg::AP_BIT;
  localparam int BC_BIT_L = sbr_pkg::BC_BIT;
  wire rd_ok   = cmd_rd && open_q[bank];
  wire rd_ap   = addr[AP_BIT_L];
  wire rd_chop = (bl == sbr_pkg::BL_FIXED4) ||
                 ((bl == sbr_pkg::BL_OTF) && !addr[BC_BIT_L]);

  // ----------------------------------------------------------------
  // per-bank row state and auto precharge
  // ----------------------------------------------------------------
  localparam logic [7:0] RAS_LOAD = 8'(sbr_pkg::RAS_CYC);
  localparam logic [7:0] RP_LOAD  = 8'(sbr_pkg::RP_CYC);
  localparam logic [7:0] AP_LOAD  = 8'(sbr_pkg::AP_MIN_CYC);
  logic [7:0] ap_pend;

  genvar b;
  generate
    for (b = 0; b < sbr_pkg::NUM_BANKS; b++) begin : g_bank
      logic [7:0] ras_cnt;
      logic [7:0] ap_cnt;
      logic [7:0] rp_cnt;
      wire        hit     = (bank == 3'(b));
      wire        pre_hit = cmd_pre && (hit || addr[AP_BIT_L]);
      wire        ap_fire = ap_pend[b] && (ap_cnt == 8'h00) && (ras_cnt == 8'h00);
      wire        do_act  = cmd_act && hit && (rp_cnt == 8'h00);
      wire        do_pre  = !do_act && pre_hit;
      wire        do_arm  = !do_act && !pre_hit && rd_ok && hit && rd_ap && !ap_pend[b];
      wire        do_fire = !do_act && !pre_hit && !do_arm && ap_fire;

      always_ff @(posedge link_clock) begin
        if (link_reset) begin
          ras_cnt <= 8'h00;
        end else if (do_act) begin
          ras_cnt <= RAS_LOAD;
        end else if (ras_cnt != 8'h00) begin
          ras_cnt <= ras_cnt - 8'h01;
        end
      end

      always_ff @(posedge link_clock) begin
        if (link_reset) begin
          ap_cnt <= 8'h00;
        end else if (do_arm) begin
          ap_cnt <= {4'h0, al} + AP_LOAD;
        end else if (ap_cnt != 8'h00) begin
          ap_cnt <= ap_cnt - 8'h01;
        end
      end

      always_ff @(posedge link_clock) begin
        if (link_reset) begin
          rp_cnt <= 8'h00;
        end else if (do_pre || do_fire) begin
          rp_cnt <= RP_LOAD;
        end else if (rp_cnt != 8'h00) begin
          rp_cnt <= rp_cnt - 8'h01;
        end
      end

      always_ff @(posedge link_clock) begin
        if (link_reset) begin
          open_q[b]  <= 1'b0;
          ap_pend[b] <= 1'b0;
        end else if (do_act) begin
          open_q[b] <= 1'b1;
        end else if (do_pre || do_fire) begin
          // tRP counts from this edge, the internal precharge instant
          open_q[b]  <= 1'b0;
          ap_pend[b] <= 1'b0;
        end else if (do_arm) begin
          ap_pend[b] <= 1'b1;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // read latency line
  // ----------------------------------------------------------------
  logic [sbr_pkg::LAT_DEPTH-1:0] lat_vld;
  logic                          lat_chop [sbr_pkg::LAT_DEPTH];
  logic [7:0]                    lat_base [sbr_pkg::LAT_DEPTH];

  genvar s;
  generate
    for (s = 0; s < sbr_pkg::LAT_DEPTH; s++) begin : g_lat
      if (s == 0) begin : g_head
        always_ff @(posedge link_clock) begin
          if (link_reset) begin
            lat_vld[s]  <= 1'b0;
            lat_chop[s] <= 1'b0;
            lat_base[s] <= 8'h00;
          end else begin
            lat_vld[s]  <= rd_ok;
            lat_chop[s] <= rd_chop;
            lat_base[s] <= addr[7:0];
          end
        end
      end else begin : g_tail
        always_ff @(posedge link_clock) begin
          if (link_reset) begin
            lat_vld[s]  <= 1'b0;
            lat_chop[s] <= 1'b0;
            lat_base[s] <= 8'h00;
          end else begin
            lat_vld[s]  <= lat_vld[s-1];
            lat_chop[s] <= lat_chop[s-1];
            lat_base[s] <= lat_base[s-1];
          end
        end
      end
    end
  endgenerate

  wire [5:0] tap_start = rl - 6'h01;
  wire [5:0] tap_pre   = rl - 6'h02;
  wire       start     = lat_vld[tap_start];
  wire       pre_due   = lat_vld[tap_pre];

  // ----------------------------------------------------------------
  // burst sequencer
  // ----------------------------------------------------------------
  logic       active;
  logic [1:0] beat;
  logic [1:0] last_beat;
  logic [7:0] base;
  wire        cont        = active && (beat != last_beat);
  wire        next_active = start || cont;
  wire [1:0]  next_beat   = start ? 2'h0 : 2'(beat + 2'h1);
  wire [1:0]  next_last   = start ? (lat_chop[tap_start] ? 2'(sbr_pkg::BC4_CYC - 1)
                                                          : 2'(sbr_pkg::BL8_CYC - 1))
                                  : last_beat;
  wire [7:0]  next_base   = start ? lat_base[tap_start] : base;
  wire [2:0]  ofs_rise    = 3'(next_base[2:0] + {next_beat, 1'b0});
  wire [2:0]  ofs_fall    = 3'(next_base[2:0] + {next_beat, 1'b1});
  wire        next_pre    = pre_due && !next_active;

  always_ff @(posedge link_clock) begin
    if (link_reset) begin
      active    <= 1'b0;
      beat      <= 2'h0;
      last_beat <= 2'h0;
      base      <= 8'h00;
    end else begin
      active    <= next_active;
      beat      <= next_beat;
      last_beat <= next_last;
      base      <= next_base;
    end
  end

  // ----------------------------------------------------------------
  // pin-facing outputs
  // ----------------------------------------------------------------
  always_ff @(posedge link_clock) begin
    if (link_reset) begin
      dq_rise <= 8'h00;
      dq_fall <= 8'h00;
    end else begin
      dq_rise <= {next_base[7:3], ofs_rise};
      dq_fall <= {next_base[7:3], ofs_fall};
    end
  end

  always_ff @(posedge link_clock) begin
    if (link_reset) begin
      dq_oe_n  <= 1'b1;
      dqs_oe_n <= 1'b1;
    end else begin
      dq_oe_n  <= !next_active;
      dqs_oe_n <= !(next_active || next_pre);
    end
  end

  always_ff @(posedge link_clock) begin
    if (link_reset) begin
      dqs_rise <= 1'b0;
      dqs_fall <= 1'b0;
    end else begin
      // strobe high then low each data cycle; the low half of the last data cycle is the postamble
      dqs_rise <= next_active;
      dqs_fall <= 1'b0;
    end
  end

  always_ff @(posedge link_clock) begin
    if (link_reset) begin
      term_en <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      term_en <= odt && !next_active && !next_pre;
      busy_q  <= next_active;
    end
  end
endmodule // sbr_read_core

// *** design/sbr_pkg.sv ***
// shared constants and the two-flop synchroniser
package sbr_pkg;
  // link clock period, in picoseconds
  localparam int LINK_PERIOD_PS = 30000;
  // analog minimum times, in picoseconds
  localparam int RTP_PS         = 7500;
  localparam int RAS_PS         = 35000;
  localparam int RP_PS          = 13750;
  // minimum times rounded up to whole link cycles
  localparam int RTP_CYC        = (RTP_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int RAS_CYC        = (RAS_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int RP_CYC         = (RP_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  // precharge never starts earlier than this after the last prefetch
  localparam int PREF_GAP_CYC   = 4;
  localparam int AP_MIN_CYC     = (RTP_CYC > PREF_GAP_CYC) ? RTP_CYC : PREF_GAP_CYC;
  // bursts
  localparam int BL8_CYC        = 4;
  localparam int BC4_CYC        = 2;
  localparam int NUM_BANKS      = 8;
  localparam int LAT_DEPTH      = 64;
  // address bit positions
  localparam int AP_BIT         = 10;
  localparam int BC_BIT         = 12;
  // burst-length field codes
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
endpackage : sbr_pkg

module sbr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,  // destination clock
  input  wire logic [WIDTH-1:0] d,      // level from the other domain
  output logic      [WIDTH-1:0] q       // synchronised level
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clock) begin
    meta <= d;
    q    <= meta;
  end
endmodule // sbr_sync

// *** tb/sbr_read_core_chk.sv ***
// concurrent checks on the read burst outputs
module sbr_read_core_chk (
  input wire logic       reset,      // reset
  input wire logic       link_clock, // memory clock
  input wire logic       cs_n,       // select
  input wire logic       ras_n,      // row strobe
  input wire logic       cas_n,      // column strobe
  input wire logic       we_n,       // write enable
  input wire logic [3:0] cfg_al,     // additive latency
  input wire logic [4:0] cfg_cl,     // CAS latency
  input wire logic [1:0] cfg_bl,     // burst field
  input wire logic       odt,        // termination request
  input wire logic       dq_oe_n,    // data enable
  input wire logic       dqs_rise,   // strobe rise half
  input wire logic       dqs_fall,   // strobe fall half
  input wire logic       dqs_oe_n,   // strobe enable
  input wire logic       term_en     // termination active
);
  wire rd = !cs_n && ras_n && !cas_n && we_n;
  default clocking cb @(posedge link_clock); endclocking
  default disable iff (reset);
  property p_pre; $fell(dqs_oe_n) |-> dq_oe_n && !dqs_rise && !dqs_fall; endproperty
  a_pre: assert property (p_pre) else $error("preamble not low");
  property p_beat; !dq_oe_n |-> !dqs_oe_n && dqs_rise && !dqs_fall; endproperty
  a_beat: assert property (p_beat) else $error("strobe wrong during data");
  property p_post;
    $rose(dq_oe_n) |-> $rose(dqs_oe_n) or (!dqs_oe_n ##1 !dq_oe_n);
  endproperty
  a_post: assert property (p_post) else $error("strobe not released with data");
  property p_bl8; $fell(dq_oe_n) && cfg_bl == 2'h0 |-> !dq_oe_n [*4]; endproperty
  a_bl8: assert property (p_bl8) else $error("long burst cut short");
  property p_bc4; $fell(dq_oe_n) && cfg_bl == 2'h2 |-> !dq_oe_n [*2] ##1 dq_oe_n; endproperty
  a_bc4: assert property (p_bc4) else $error("chopped burst wrong length");
  property p_lat; $fell(dqs_oe_n) && cfg_al == 4'h0 && cfg_cl == 5'h05 |-> $past(rd, 5); endproperty
  a_lat: assert property (p_lat) else $error("preamble without read at latency");
  property p_term; dqs_oe_n && $past(dqs_oe_n) && $stable(odt) |-> term_en == odt; endproperty
  a_term: assert property (p_term) else $error("termination not following request");
  property p_drv; dqs_oe_n |-> dq_oe_n; endproperty
  a_drv: assert property (p_drv) else $error("data driven without strobe");
  c_bl8: cover property ($fell(dq_oe_n) && cfg_bl == 2'h0);
  c_bc4: cover property ($fell(dq_oe_n) && cfg_bl == 2'h2);
  c_term: cover property ($rose(term_en));
endmodule // sbr_read_core_chk

bind sbr_read_core sbr_read_core_chk chk (.reset(reset), .link_clock(link_clock),
  .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .cfg_al(cfg_al),
  .cfg_cl(cfg_cl), .cfg_bl(cfg_bl), .odt(odt), .dq_oe_n(dq_oe_n), .dqs_rise(dqs_rise),
  .dqs_fall(dqs_fall), .dqs_oe_n(dqs_oe_n), .term_en(term_en));

// *** tb/sbr_ctrl_model.sv ***
// controller model issuing commands on the memory clock
module sbr_ctrl_model (
  input  wire logic        link_clock, // memory clock
  output logic             cs_n,       // select
  output logic             ras_n,      // row strobe
  output logic             cas_n,      // column strobe
  output logic             we_n,       // write enable
  output logic [2:0]       bank,       // bank
  output logic [13:0]      addr        // address
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    bank = 3'h0;
    addr = 14'h0000;
  end
  // one command, then deselected with scrambled lines for gap cycles
  task automatic cmd(input logic [2:0] rcw, input logic [2:0] b, input logic [13:0] a,
                     input int gap);
    @(posedge link_clock);
    cs_n <= 1'b0;
    {ras_n, cas_n, we_n} <= rcw;
    bank <= b;
    addr <= a;
    @(posedge link_clock);
    cs_n <= 1'b1;
    bank <= ~b;
    addr <= ~a;
    repeat (gap) @(posedge link_clock);
  endtask
endmodule // sbr_ctrl_model

// *** tb/test_sbr_read_core.sv ***
// self-checking bench for the read burst core
module test_sbr_read_core;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [2:0] ACT = 3'h3;
  localparam logic [2:0] RD  = 3'h5;
  localparam logic [2:0] PRE = 3'h2;
  logic       clock, reset, link_clock, odt;
  logic [3:0] cfg_al;
  logic [4:0] cfg_cl;
  logic [1:0] cfg_bl;
  wire        cs_n, ras_n, cas_n, we_n, read_busy, dq_oe_n, dqs_rise, dqs_fall, dqs_oe_n, term_en;
  wire [2:0]  bank;
  wire [13:0] addr;
  wire [7:0]  bank_open, dq_rise, dq_fall;
  int         n_errors = 0, cmp_count = 0, ticks = 0;
  logic [7:0] f0, fl;
  logic       busy_seen;
  sbr_read_core dut (.clock(clock), .reset(reset), .cfg_al(cfg_al), .cfg_cl(cfg_cl),
    .cfg_bl(cfg_bl), .bank_open(bank_open), .read_busy(read_busy), .link_clock(link_clock),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank(bank), .addr(addr),
    .odt(odt), .dq_rise(dq_rise), .dq_fall(dq_fall), .dq_oe_n(dq_oe_n), .dqs_rise(dqs_rise),
    .dqs_fall(dqs_fall), .dqs_oe_n(dqs_oe_n), .term_en(term_en));
  sbr_ctrl_model model (.link_clock(link_clock), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bank(bank), .addr(addr));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    link_clock = 1'b0;
    #7;
    forever #15 link_clock = ~link_clock;
  end
  always @(posedge clock) begin
    ticks <= ticks + 1;
    if (ticks == 4000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [2:0] b, input logic [7:0] col, input logic a12,
                    input logic ap, input int gap);
    model.cmd(RD, b, {1'b0, a12, 1'b0, ap, 2'h0, col}, gap);
  endtask
  // data cycles, first and last index, first beat
  task automatic watch(output int n, output int f, output int l, output logic [7:0] b0);
    n = 0;
    f = -1;
    l = -1;
    b0 = 8'h00;
    f0 = 8'h00;
    fl = 8'h00;
    busy_seen = 1'b0;
    for (int k = 1; k <= 24; k++) begin
      @(posedge link_clock);
      #1;
      if (read_busy === 1'b1) busy_seen = 1'b1;
      if (dq_oe_n === 1'b0) begin
        if (f < 0) b0 = dq_rise;
        if (f < 0) f0 = dq_fall;
        if (f < 0) f = k;
        fl = dq_fall;
        l = k;
        n++;
      end
    end
  endtask
  task automatic setcfg(input logic [3:0] a, input logic [1:0] b);
    @(posedge clock);
    cfg_al <= a;
    cfg_bl <= b;
    repeat (3) @(posedge clock);
  endtask
  //----------------------------------------
  // scenarios
  //----------------------------------------
  task automatic t_basic();
    int n, f, l;
    logic [7:0] b0;
    model.cmd(ACT, 3'h1, 14'h0123, 0);
    rd(3'h1, 8'h2A, 1'b1, 1'b0, 0);
    watch(n, f, l, b0);
    check(f, 5);
    check(n, 4);
    check(b0, 8'h2A);
    check(f0, 8'h2B);
    check(fl, 8'h29);
    check(busy_seen, 1'b1);
    check(bank_open, 8'h02);
    rd(3'h3, 8'h2A, 1'b1, 1'b0, 0);
    watch(n, f, l, b0);
    check(n, 0);
    check(busy_seen, 1'b0);
  endtask
  task automatic t_modes();
    int n, f, l;
    logic [7:0] b0;
    int al[5] = '{0, 0, 0, 0, 2};
    int bl[5] = '{0, 1, 1, 2, 0};
    int bc[5] = '{0, 1, 0, 1, 1};
    int nb[5] = '{4, 4, 2, 2, 4};
    for (int i = 0; i < 5; i++) begin
      setcfg(al[i][3:0], bl[i][1:0]);
      rd(3'h1, 8'h40, bc[i][0], 1'b0, 0);
      watch(n, f, l, b0);
      check(f, al[i] + 5);
      check(n, nb[i]);
    end
  endtask
  task automatic t_concat();
    int n, f, l;
    logic [7:0] b0;
    for (int i = 0; i < 2; i++) begin
      setcfg(4'h0, i ? 2'h2 : 2'h0);
      rd(3'h1, 8'h10, 1'b1, 1'b0, 2);
      fork
        rd(3'h1, 8'h18, 1'b1, 1'b0, 0);
      join_none
      watch(n, f, l, b0);
      check(n, i ? 4 : 8);
      check(l - f + 1, i ? 6 : 8);
    end
    setcfg(4'h0, 2'h0);
  endtask
  task automatic t_autopre();
    int n, f, l;
    logic [7:0] b0;
    rd(3'h1, 8'h20, 1'b1, 1'b1, 0);
    watch(n, f, l, b0);
    check(n, 4);
    check(bank_open, 8'h00);
    rd(3'h1, 8'h20, 1'b1, 1'b0, 0);
    watch(n, f, l, b0);
    check(n, 0);
    model.cmd(ACT, 3'h1, 14'h0456, 0);
    rd(3'h1, 8'h28, 1'b1, 1'b0, 0);
    watch(n, f, l, b0);
    check(n, 4);
    model.cmd(PRE, 3'h5, 14'h0400, 0);
    rd(3'h1, 8'h28, 1'b1, 1'b0, 0);
    watch(n, f, l, b0);
    check(n, 0);
    check(bank_open, 8'h00);
  endtask
  task automatic t_odt();
    @(posedge link_clock);
    odt <= 1'b1;
    repeat (4) @(posedge link_clock);
    odt <= 1'b0;
    #1;
    check(term_en, 1'b1);
    repeat (4) @(posedge link_clock);
    #1;
    check(term_en, 1'b0);
  endtask
  initial begin
    reset = 1'b1;
    odt = 1'b0;
    cfg_al = 4'h0;
    cfg_cl = 5'h05;
    cfg_bl = 2'h0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    repeat (20) @(posedge link_clock);
    t_basic();
    $display("basic done");
    t_modes();
    $display("modes done");
    t_concat();
    $display("concat done");
    t_autopre();
    $display("autopre done");
    t_odt();
    $display("odt done");
    conclude();
  end
endmodule // test_sbr_read_core
